// ==== verilog/rqd_pkg.sv ====
// Package for the rotation quadrature decoder: register map, table entry
// field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus and byte addressed words.
package rqd_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_MASK    = 8'h08;
    localparam logic [7:0] REG_FWD     = 8'h0c;
    localparam logic [7:0] REG_NET     = 8'h10;
    localparam logic [7:0] REG_REV     = 8'h14;
    localparam logic [7:0] REG_STATE   = 8'h18;
    localparam logic [7:0] REG_TABLE   = 8'h40;
    localparam int         TABLE_WORDS = 16;

    // Table entry fields
    localparam int NEXT_LOW_POS  = 0;
    localparam int COUNT_UP_POS  = 1;
    localparam int COUNT_DN_POS  = 2;
    localparam int NEXT_HIGH_POS = 3;
    localparam int CW_FLAG_POS   = 6;
    localparam int SKIP_FLAG_POS = 7;

    // Control bits
    localparam int CTRL_EN_POS   = 0;
    localparam int CTRL_CLR_POS  = 1;

    // Status / mask bits
    localparam int STS_SKIP_POS  = 0;
    localparam int STS_CW_POS    = 1;

    localparam logic [31:0] CNT_RST   = 32'h0000_0000;
    localparam logic [7:0]  ENTRY_RST = 8'h00;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    // Position codes, neighbours differ in one bit
    localparam logic [1:0] BOTH_METAL_POSITION      = 2'h0;
    localparam logic [1:0] A_OPEN_B_METAL_POSITION  = 2'h1;
    localparam logic [1:0] BOTH_OPEN_POSITION       = 2'h3;
    localparam logic [1:0] A_METAL_B_OPEN_POSITION  = 2'h2;

    typedef enum logic [1:0] {
        RQD_WAIT_FIRST,
        RQD_RUN
    } rqd_phase_type;
endpackage

// ==== verilog/rqd_counter.sv ====
// Up/down 32-bit counter with synchronous clear.
// Assumes one step request per cycle at most.
`timescale 1ns/1ps
module rqd_counter
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clr,
    input  wire logic        inc,
    input  wire logic        dec,
    output logic [31:0]      count
);
    logic [31:0] count_ff;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            count_ff <= rqd_pkg::CNT_RST;
        else if (clr)
            count_ff <= rqd_pkg::CNT_RST;
        else if (inc && !dec)
            count_ff <= count_ff + 32'h0000_0001;
        else if (dec && !inc)
            count_ff <= count_ff - 32'h0000_0001;
    end

    assign count = count_ff;
endmodule

// ==== verilog/rqd_top.sv ====
// Rotation quadrature decoder: table-driven position machine with three
// rotation counters, sticky event flags and an AHB-Lite register slave.
// Assumes the sensor latch bits are synchronous to clk and that a new
// sample is announced by a one-cycle sample strobe.
`timescale 1ns/1ps
module rqd_top
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        sample_stb,
    input  wire logic        sensor_channel_a,
    input  wire logic        sensor_channel_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic [1:0]       position_state
);
    // Entry index: present state then channel b then channel a
    function automatic logic [3:0] table_index(input logic [1:0] st,
                                               input logic       ch_b,
                                               input logic       ch_a);
        table_index = {st, ch_b, ch_a};
    endfunction

    function automatic logic [1:0] entry_next(input logic [7:0] e);
        entry_next = {e[rqd_pkg::NEXT_HIGH_POS], e[rqd_pkg::NEXT_LOW_POS]};
    endfunction

    logic [7:0]  table_ff [rqd_pkg::TABLE_WORDS];
    logic [1:0]  state_ff;
    rqd_pkg::rqd_phase_type phase_ff;
    logic        enable_ff;
    logic [1:0]  status_ff;
    logic [1:0]  mask_ff;
    logic        irq_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    logic [1:0]  state_out_ff;
    logic        hresp_ff;

    logic        bus_take;
    logic        wr_now;
    logic [7:0]  entry;
    logic        step_en;
    logic        cnt_clr;
    logic        fwd_inc;
    logic        rev_inc;
    logic [1:0]  evt;
    logic [1:0]  nxt_status;
    logic [31:0] fwd_count;
    logic [31:0] net_count;
    logic [31:0] rev_count;
    logic [31:0] rd_word;

    // Bus address phase; the write completes in the following data phase
    assign bus_take = hsel && hready && htrans[1];
    assign wr_now   = wr_pend_ff;

    // Decoder step
    assign entry   = table_ff[table_index(state_ff, sensor_channel_b,
                                          sensor_channel_a)];
    assign step_en = sample_stb && enable_ff && (phase_ff == rqd_pkg::RQD_RUN);
    assign fwd_inc = step_en && entry[rqd_pkg::COUNT_UP_POS];
    assign rev_inc = step_en && entry[rqd_pkg::COUNT_DN_POS];
    assign cnt_clr = wr_now && (wr_addr_ff == rqd_pkg::REG_CTRL)
                     && hwdata[rqd_pkg::CTRL_CLR_POS];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= rqd_pkg::BOTH_METAL_POSITION;
            phase_ff <= rqd_pkg::RQD_WAIT_FIRST;
        end
        else if (sample_stb && enable_ff)
        begin
            case (phase_ff)
                rqd_pkg::RQD_WAIT_FIRST:
                begin
                    // Gray position from channels: a is bit0 flipped order
                    // so that b,a 00->00, 01->01... matches codes
                    state_ff <= {sensor_channel_b, sensor_channel_a};
                    phase_ff <= rqd_pkg::RQD_RUN;
                end
                rqd_pkg::RQD_RUN:
                    state_ff <= entry_next(entry);
                default:
                    phase_ff <= rqd_pkg::RQD_WAIT_FIRST;
            endcase
        end
    end

    // Forward and reverse counters; net is their difference
    rqd_counter u_fwd
    (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (cnt_clr),
        .inc    (fwd_inc),
        .dec    (1'b0),
        .count  (fwd_count)
    );

    rqd_counter u_net
    (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (cnt_clr),
        .inc    (fwd_inc),
        .dec    (rev_inc),
        .count  (net_count)
    );

    rqd_counter u_rev
    (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (cnt_clr),
        .inc    (rev_inc),
        .dec    (1'b0),
        .count  (rev_count)
    );

    // Sticky events; a new event wins over a write-one clear
    assign evt[rqd_pkg::STS_SKIP_POS] = step_en
                                        && entry[rqd_pkg::SKIP_FLAG_POS];
    assign evt[rqd_pkg::STS_CW_POS]   = step_en
                                        && entry[rqd_pkg::CW_FLAG_POS];

    always_comb
    begin
        nxt_status = status_ff;
        if (wr_now && (wr_addr_ff == rqd_pkg::REG_STATUS))
            nxt_status = status_ff & ~hwdata[1:0];
        nxt_status = nxt_status | evt;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status_ff <= 2'h0;
        else
            status_ff <= nxt_status;
    end

    // Built from the next status so irq rises with the flag itself; a mask
    // change shows one edge after the mask register takes it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(nxt_status & mask_ff);
    end

    // Control register; the clear bit is not stored, it acts on the write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            enable_ff <= 1'b0;
        else if (wr_now && (wr_addr_ff == rqd_pkg::REG_CTRL))
            enable_ff <= hwdata[rqd_pkg::CTRL_EN_POS];
    end

    // Mask register, same layout as status
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_ff <= rqd_pkg::MASK_RST;
        else if (wr_now && (wr_addr_ff == rqd_pkg::REG_MASK))
            mask_ff <= hwdata[1:0];
    end

    // Table loaded by software; spare bits stored as written
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < rqd_pkg::TABLE_WORDS; i++)
                table_ff[i] <= rqd_pkg::ENTRY_RST;
        end
        else if (wr_now && (wr_addr_ff[7:6] == rqd_pkg::REG_TABLE[7:6]))
            table_ff[wr_addr_ff[5:2]] <= hwdata[7:0];
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            rqd_pkg::REG_CTRL:   rd_word = {31'h0, enable_ff};
            rqd_pkg::REG_STATUS: rd_word = {30'h0, status_ff};
            rqd_pkg::REG_MASK:   rd_word = {30'h0, mask_ff};
            rqd_pkg::REG_FWD:    rd_word = fwd_count;
            rqd_pkg::REG_NET:    rd_word = net_count;
            rqd_pkg::REG_REV:    rd_word = rev_count;
            rqd_pkg::REG_STATE:  rd_word = {29'h0, phase_ff == rqd_pkg::RQD_RUN,
                                            state_ff};
            default:
            begin
                if (haddr[7:6] == rqd_pkg::REG_TABLE[7:6])
                    rd_word = {24'h0, table_ff[haddr[5:2]]};
            end
        endcase
    end

    // Zero-wait slave: hreadyout never drops, so no wait state exists
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hreadyout_ff <= 1'b1;
        else
            hreadyout_ff <= 1'b1;
    end

    // Only OKAY is answered; hsize is ignored, every access is a word
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hresp_ff <= 1'b0;
        else
            hresp_ff <= 1'b0;
    end

    // A write is remembered for one cycle and lands in its data phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wr_pend_ff <= 1'b0;
        else
            wr_pend_ff <= bus_take && hwrite;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wr_addr_ff <= 8'h00;
        else if (bus_take)
            wr_addr_ff <= haddr[7:0];
    end

    // Read data captured at the address phase edge and held until the next
    // read; a read right behind a write to the same word sees the old value
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata_ff <= 32'h0000_0000;
        else if (bus_take && !hwrite)
            hrdata_ff <= rd_word;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_out_ff <= rqd_pkg::BOTH_METAL_POSITION;
        else
            state_out_ff <= state_ff;
    end

    assign hrdata         = hrdata_ff;
    assign hreadyout      = hreadyout_ff;
    assign hresp          = hresp_ff;
    assign irq            = irq_ff;
    assign position_state = state_out_ff;
endmodule

// ==== verif/rqd_monitor.sv ====
// Checker for the decoder's bus, irq and state outputs.
// Assumes it is bound to rqd_top and sees only its ports.
`timescale 1ns/1ps
module rqd_monitor
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        sample_stb,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic [1:0]  position_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic tk;
    logic seen_wr_ff;
    assign tk = hsel && htrans[1];
    // Mask resets to zero, so irq cannot rise before any write
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            seen_wr_ff <= 1'b0;
        else if (tk && hwrite)
            seen_wr_ff <= 1'b1;
    sequence s_quiet;
        !sample_stb ##1 !sample_stb;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait state");
    a_rdata_holds: assert property
        (!$past(tk && !hwrite) |-> $stable(hrdata))
        else $error("read data moved without a read");
    a_state_cause: assert property
        ($changed(position_state) |-> $past(sample_stb, 2))
        else $error("state moved without a sample");
    a_state_idle: assert property (s_quiet |=> $stable(position_state))
        else $error("state moved while idle");
    a_irq_cause: assert property
        ($rose(irq) |-> $past(sample_stb) || $past(tk && hwrite, 3))
        else $error("irq rose without cause");
    a_irq_clear: assert property
        ($fell(irq) |-> $past(tk && hwrite, 2) || $past(tk && hwrite, 3))
        else $error("irq fell without a write");
    a_irq_masked: assert property (!seen_wr_ff |-> !irq)
        else $error("irq high with reset mask");
endmodule
bind rqd_top rqd_monitor u_rqd_monitor (.clk(clk), .arst_n(arst_n),
    .sample_stb(sample_stb), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .position_state(position_state));

// ==== verif/rqd_sensor_model.sv ====
// Model of the sampled two-channel sensor latch.
// Assumes the bench requests one sample at a time with a go pulse.
`timescale 1ns/1ps
module rqd_sensor_model
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       go,
    input  wire logic [1:0] code,
    output logic            sample_stb,
    output logic            sensor_channel_a,
    output logic            sensor_channel_b
);
    // Latch bits hold between samples, as the real latch does
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            sample_stb <= 1'b0;
            {sensor_channel_b, sensor_channel_a} <= 2'h0;
        end
        else
        begin
            sample_stb <= go;
            if (go)
                {sensor_channel_b, sensor_channel_a} <= code;
        end
endmodule

// ==== verif/rqd_top_tb.sv ====
// Self-checking bench for the rotation quadrature decoder.
// Assumes a single AHB-Lite slave, so hreadyout feeds hready.
`timescale 1ns/1ps
module rqd_top_tb;
    logic        clk = 1'b0, arst_n = 1'b0, go = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, first = 1'b1;
    logic [1:0]  code = 2'h0, htrans = 2'h0, st, sts;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, fwd, rev, net;
    logic        hreadyout, hresp, irq, stb, cha, chb;
    logic [1:0]  position_state;
    int          failures = 0, n_tests = 0;
    // Reference table, spare bits left clear
    logic [7:0]  tbl [16] = '{8'h00, 8'h43, 8'h0c, 8'h89, 8'h04, 8'h01,
        8'h88, 8'h4b, 8'h42, 8'h81, 8'h08, 8'h0d, 8'h80, 8'h05, 8'h4a,
        8'h09};
    always #20 clk = ~clk;
    rqd_sensor_model u_rqd_sensor_model (.clk(clk), .arst_n(arst_n),
        .go(go), .code(code), .sample_stb(stb), .sensor_channel_a(cha),
        .sensor_channel_b(chb));
    rqd_top u_rqd_top (.clk(clk), .arst_n(arst_n), .sample_stb(stb),
        .sensor_channel_a(cha), .sensor_channel_b(chb), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .position_state(position_state));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!hreadyout);
        rd = hrdata;
    endtask
    task samp(input logic [1:0] c);
        logic [7:0] e;
        e = tbl[{st, c}];
        go <= 1'b1;
        code <= c;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        if (first)
            st = c;
        else
        begin
            st = {e[3], e[0]};
            fwd = fwd + 32'(e[1]);
            rev = rev + 32'(e[2]);
            net = net + 32'(e[1]) - 32'(e[2]);
            sts = sts | {e[6], e[7]};
        end
        first = 1'b0;
        chk({30'h0, position_state}, {30'h0, st});
    endtask
    task regs;
        bus(rqd_pkg::REG_FWD, 1'b0, 32'h0);
        chk(rd, fwd);
        bus(rqd_pkg::REG_NET, 1'b0, 32'h0);
        chk(rd, net);
        bus(rqd_pkg::REG_REV, 1'b0, 32'h0);
        chk(rd, rev);
        bus(rqd_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(rd, {30'h0, sts});
    endtask
    task t_reset;
        regs();
        bus(rqd_pkg::REG_MASK, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(8'h3c, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_load;
        for (int i = 0; i < 16; i++)
            bus(rqd_pkg::REG_TABLE + 8'(i * 4), 1'b1, {24'h0, tbl[i]});
        bus(rqd_pkg::REG_TABLE + 8'h1c, 1'b0, 32'h0);
        chk(rd, 32'h4b);
        bus(rqd_pkg::REG_CTRL, 1'b1, 32'h1);
    endtask
    task t_cw;
        samp(2'h0);
        samp(2'h1);
        samp(2'h3);
        samp(2'h2);
        samp(2'h2);
        samp(2'h0);
        regs();
        bus(rqd_pkg::REG_FWD, 1'b0, 32'h0);
        chk(rd, 32'h4);
    endtask
    task t_ccw;
        samp(2'h2);
        samp(2'h3);
        samp(2'h1);
        samp(2'h0);
        regs();
        bus(rqd_pkg::REG_REV, 1'b0, 32'h0);
        chk(rd, 32'h4);
    endtask
    task t_clear;
        bus(rqd_pkg::REG_STATE, 1'b0, 32'h0);
        chk(rd, {29'h0, 1'b1, st});
        bus(rqd_pkg::REG_CTRL, 1'b1, 32'h3);
        bus(rqd_pkg::REG_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h1);
        fwd = 32'h0;
        rev = 32'h0;
        net = 32'h0;
        regs();
    endtask
    task t_skip;
        samp(2'h3);
        samp(2'h0);
        regs();
    endtask
    task t_irq;
        chk({31'h0, irq}, 32'h0);
        bus(rqd_pkg::REG_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(rqd_pkg::REG_STATUS, 1'b1, 32'h3);
        sts = 2'h0;
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // Clockwise flag is masked off here, so irq must stay low
        samp(2'h1);
        chk({31'h0, irq}, 32'h0);
        bus(rqd_pkg::REG_MASK, 1'b1, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        regs();
    endtask
    task t_rst2;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk({29'h0, irq, position_state}, 32'h0);
        fwd = 32'h0;
        rev = 32'h0;
        net = 32'h0;
        st = 2'h0;
        sts = 2'h0;
        first = 1'b1;
        t_reset();
        bus(rqd_pkg::REG_TABLE + 8'h1c, 1'b0, 32'h0);
        chk(rd, 32'h0);
        t_load();
        bus(rqd_pkg::REG_MASK, 1'b1, 32'h3);
        samp(2'h3);
        samp(2'h2);
        chk({31'h0, irq}, 32'h1);
        regs();
    endtask
    task summarize;
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        fwd = 32'h0;
        rev = 32'h0;
        net = 32'h0;
        st = 2'h0;
        sts = 2'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_load();
        t_cw();
        t_ccw();
        t_skip();
        t_clear();
        t_irq();
        t_rst2();
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
